/* include/pvi_regs.vh */
// Register map, field positions, reset values and timing constants of the video input port
`ifndef PVI_REGS_VH
`define PVI_REGS_VH

`define PVI_ADDR_CTRL      8'h00
`define PVI_ADDR_STATUS    8'h04
`define PVI_ADDR_FRM_IN    8'h08
`define PVI_ADDR_FRM_OUT   8'h0C
`define PVI_ADDR_LINES     8'h10
`define PVI_ADDR_TIMEOUT   8'h14

`define PVI_CTRL_ENABLE    0
`define PVI_CTRL_VS_FALL   1
`define PVI_CTRL_HS_FALL   2
`define PVI_CTRL_MASK_LOW  3
`define PVI_CTRL_FMT_LO    4
`define PVI_CTRL_FMT_HI    5
`define PVI_CTRL_RESET     6'h00

`define PVI_ST_RUN         0
`define PVI_ST_ILLUM       1
`define PVI_ST_GLASSES     2
`define PVI_ST_MASKED      3
`define PVI_ST_OVERFLOW    4
`define PVI_ST_EMPTY       5

`define PVI_FMT_24         2'h0
`define PVI_FMT_18         2'h1
`define PVI_FMT_16         2'h2

`define PVI_RESP_OKAY      2'h0
`define PVI_RESP_SLVERR    2'h2

`define PVI_CLK_MHZ        50
`define PVI_VS_TIMEOUT_MS  50
`define PVI_VS_TIMEOUT_CYC (`PVI_VS_TIMEOUT_MS * `PVI_CLK_MHZ * 1000)

`endif

/* src/pvi_fifo.v */
// Parameterised synchronous FIFO with valid and ready on both sides
module pvi_fifo #(
	parameter WIDTH = 27,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW:0]      wr_ptr_ff;
	reg [AW:0]      rd_ptr_ff;
	wire            full;
	wire            empty;
	wire            do_wr;
	wire            do_rd;

	// Extra pointer bit tells full from empty
	assign empty     = (wr_ptr_ff == rd_ptr_ff);
	assign full      = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) && (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem_ff[rd_ptr_ff[AW-1:0]];
	assign do_wr     = in_valid & ~full;
	assign do_rd     = out_ready & ~empty;

	// Storage has no reset; only the pointers carry state
	always @(posedge aclk) begin
		if (do_wr) begin
			mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
		end
	end

	// Pointer update
	always @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_ff <= {(AW+1){1'b0}};
			rd_ptr_ff <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr_ff <= wr_ptr_ff + {{AW{1'b0}}, 1'b1};
			end
			if (do_rd) begin
				rd_ptr_ff <= rd_ptr_ff + {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule

/* src/pvi_top.v */
// Parallel video input port: pin sampling, frame control, pixel formatting and AXI4-Lite registers
//
// Contract
// - When frame sync stops, the sequencer halts and the illumination is switched off.
// - Frame sync and line sync each take either edge as active edge, as configured.
// - While the update mask is active, source frames are blocked and the last image stays shown.
// - The mask polarity is programmable, active high after reset.
// - Pixels are 24-bit on 24 lines, 18-bit on 18 lines, or 16-bit 4:2:2.
// - In 4:2:2, even pixels carry Cb and odd pixels Cr; both output pixels of a pair take that Cb and that Cr.
// - One output frame is shown for each unmasked input frame.
// - A glasses sync output follows the eye of the displayed image.
// - No portrait rotation is offered; images pass in landscape order only.
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`include "pvi_regs.vh"

module pvi_top #(
	parameter        DEPTH      = 16,
	parameter        AW         = 4,
	parameter [31:0] VS_TIMEOUT = `PVI_VS_TIMEOUT_CYC
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        pixel_clk_in,
	input  wire        frame_sync_in,
	input  wire        line_sync_in,
	input  wire        pixel_valid_in,
	input  wire [23:0] pixel_bus_in,
	input  wire        frame_update_mask,
	input  wire        eye_select_in,
	output wire        pix_out_valid,
	input  wire        pix_out_ready,
	output wire [23:0] pix_out_data,
	output wire        pix_out_sof,
	output wire        pix_out_sol,
	output wire        pix_out_eye,
	output wire        glasses_sync,
	output wire        seq_run,
	output wire        illum_en
);
	localparam FW = 27;

	// Pin synchronisers; stage 1 feeds stage 2 only
	reg  [29:0]   s1_ff;
	reg  [29:0]   s2_ff;
	reg  [2:0]    s3_ff;
	// Registers
	reg  [5:0]    ctrl_ff;
	reg  [31:0]   timeout_ff;
	reg  [31:0]   frm_in_ff;
	reg  [31:0]   frm_out_ff;
	reg  [31:0]   line_cnt_ff;
	reg  [31:0]   lines_ff;
	reg  [31:0]   vs_age_ff;
	reg           run_ff;
	reg           masked_ff;
	reg           eye_ff;
	reg           sof_pend_ff;
	reg           sol_pend_ff;
	reg           ovf_ff;
	reg           glasses_ff;
	reg           phase_ff;
	reg  [7:0]    y0_ff;
	reg  [7:0]    cb_ff;
	reg           pend_ff;
	reg  [FW-1:0] pend_word_ff;
	// AXI state
	reg           aw_ok_ff;
	reg  [7:0]    awaddr_ff;
	reg           w_ok_ff;
	reg  [31:0]   wdata_ff;
	reg  [3:0]    wstrb_ff;
	reg           bvalid_ff;
	reg  [1:0]    bresp_ff;
	reg           rvalid_ff;
	reg  [31:0]   rdata_ff;
	reg  [1:0]    rresp_ff;

	wire          pclk_s  = s2_ff[29];
	wire          vs_s    = s2_ff[28];
	wire          hs_s    = s2_ff[27];
	wire          valid_s = s2_ff[26];
	wire          mask_s  = s2_ff[25];
	wire          eye_s   = s2_ff[24];
	wire [23:0]   data_s  = s2_ff[23:0];
	wire          enable  = ctrl_ff[`PVI_CTRL_ENABLE];
	wire [1:0]    fmt     = ctrl_ff[`PVI_CTRL_FMT_HI:`PVI_CTRL_FMT_LO];
	wire          pclk_rise;
	wire          vs_edge;
	wire          hs_edge;
	wire          mask_act;
	wire          capture;
	wire          emit;
	reg  [23:0]   cur_pix;
	wire [FW-1:0] cur_word;
	wire [FW-1:0] wr_word;
	wire          wr_valid;
	wire          wr_ready;
	wire          wr_take;
	wire [FW-1:0] rd_word;
	wire          out_take;
	wire          wr_fire;
	wire          ovf_set;

	// Sample every pin; the pixel clock is a plain input seen through the same two stages
	always @(posedge aclk) begin
		if (!aresetn) begin
			s1_ff <= 30'h0;
			s2_ff <= 30'h0;
			s3_ff <= 3'h0;
		end else begin
			s1_ff <= {pixel_clk_in, frame_sync_in, line_sync_in, pixel_valid_in,
				frame_update_mask, eye_select_in, pixel_bus_in};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff[29:27];
		end
	end

	// Edge finders on the synchronised levels
	assign pclk_rise = pclk_s & ~s3_ff[2];
	assign vs_edge   = ctrl_ff[`PVI_CTRL_VS_FALL] ? (~vs_s & s3_ff[1]) : (vs_s & ~s3_ff[1]);
	assign hs_edge   = ctrl_ff[`PVI_CTRL_HS_FALL] ? (~hs_s & s3_ff[0]) : (hs_s & ~s3_ff[0]);
	// Low input never masks with default polarity, so an unused pin disables masking
	assign mask_act  = mask_s ^ ctrl_ff[`PVI_CTRL_MASK_LOW];
	// Pixels are taken only in unmasked frames of a running sequencer
	assign capture   = pclk_rise & valid_s & enable & run_ff & ~masked_ff;
	// In 4:2:2 the pair is complete only on the odd pixel
	assign emit      = (fmt != `PVI_FMT_16) | phase_ff;

	// Format each pin word into 8-bit channels; rows stream in arrival order, no rotation
	always @* begin
		cur_pix = data_s;
		case (fmt)
			`PVI_FMT_24: cur_pix = data_s;
			`PVI_FMT_18: cur_pix = {data_s[17:12], data_s[17:16], data_s[11:6],
				data_s[11:10], data_s[5:0], data_s[5:4]};
			`PVI_FMT_16: cur_pix = {y0_ff, cb_ff, data_s[7:0]};
			default: cur_pix = data_s;
		endcase
	end

	assign cur_word = {sof_pend_ff, sol_pend_ff, eye_ff, cur_pix};
	assign wr_valid = pend_ff | (capture & emit);
	assign wr_word  = pend_ff ? pend_word_ff : cur_word;
	assign wr_take  = wr_valid & wr_ready;
	assign wr_fire  = capture & emit & ~pend_ff & wr_ready;
	// A pixel that finds the buffer busy is lost and flagged; video cannot be stalled
	assign ovf_set  = capture & ((emit & ~wr_ready) | pend_ff);

	// Frame and line control
	always @(posedge aclk) begin
		if (!aresetn) begin
			run_ff      <= 1'b0;
			masked_ff   <= 1'b0;
			eye_ff      <= 1'b0;
			sof_pend_ff <= 1'b0;
			sol_pend_ff <= 1'b0;
			frm_in_ff   <= 32'h00000000;
			line_cnt_ff <= 32'h00000000;
			lines_ff    <= 32'h00000000;
			vs_age_ff   <= 32'h00000000;
			phase_ff    <= 1'b0;
			y0_ff       <= 8'h00;
			cb_ff       <= 8'h00;
			pend_ff     <= 1'b0;
			pend_word_ff <= {FW{1'b0}};
		end else begin
			if (vs_edge) begin
				vs_age_ff <= 32'h00000000;
			end else if (vs_age_ff != 32'hFFFFFFFF) begin
				vs_age_ff <= vs_age_ff + 32'h00000001;
			end
			// Lost frame sync or disable halts the sequencer and darkens the lamps
			if (!enable || (!vs_edge && vs_age_ff >= timeout_ff)) begin
				run_ff <= 1'b0;
			end else if (vs_edge) begin
				run_ff <= 1'b1;
			end
			if (vs_edge) begin
				// Mask only moves in blanking, so sampling it here holds for the whole frame
				masked_ff   <= mask_act;
				eye_ff      <= eye_s;
				sof_pend_ff <= ~mask_act;
				frm_in_ff   <= frm_in_ff + 32'h00000001;
				lines_ff    <= line_cnt_ff;
				line_cnt_ff <= 32'h00000000;
			end else if (hs_edge) begin
				line_cnt_ff <= line_cnt_ff + 32'h00000001;
				sol_pend_ff <= 1'b1;
				phase_ff    <= 1'b0;
			end
			if (vs_edge || hs_edge) begin
				phase_ff <= 1'b0;
			end else if (capture) begin
				phase_ff <= ~phase_ff;
				if (!phase_ff) begin
					y0_ff <= data_s[15:8];
					cb_ff <= data_s[7:0];
				end
			end
			if (wr_fire) begin
				sof_pend_ff <= 1'b0;
				sol_pend_ff <= 1'b0;
			end
			// Odd 4:2:2 pixel reuses the chroma of the preceding even pixel
			if (pend_ff && wr_take) begin
				pend_ff <= 1'b0;
			end else if (wr_fire && fmt == `PVI_FMT_16) begin
				pend_ff      <= 1'b1;
				pend_word_ff <= {1'b0, 1'b0, eye_ff, data_s[15:8], cb_ff, data_s[7:0]};
			end
		end
	end

	// Output side: each frame start leaving the buffer is one displayed frame
	assign out_take = pix_out_valid & pix_out_ready;
	always @(posedge aclk) begin
		if (!aresetn) begin
			frm_out_ff <= 32'h00000000;
			glasses_ff <= 1'b0;
		end else if (out_take && rd_word[26]) begin
			frm_out_ff <= frm_out_ff + 32'h00000001;
			glasses_ff <= rd_word[24];
		end
	end

	pvi_fifo #(
		.WIDTH (FW),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (wr_word),
		.out_valid (pix_out_valid),
		.out_ready (pix_out_ready),
		.out_data  (rd_word)
	);

	assign pix_out_data = rd_word[23:0];
	assign pix_out_eye  = rd_word[24];
	assign pix_out_sol  = rd_word[25];
	assign pix_out_sof  = rd_word[26];
	assign glasses_sync = glasses_ff;
	assign seq_run      = run_ff;
	assign illum_en     = run_ff;

	// AXI write: address and data taken in either order, then one response
	assign s_axi_awready = ~aw_ok_ff & ~bvalid_ff;
	assign s_axi_wready  = ~w_ok_ff & ~bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_ff   <= 1'b0;
			w_ok_ff    <= 1'b0;
			awaddr_ff  <= 8'h00;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `PVI_RESP_OKAY;
			ctrl_ff    <= `PVI_CTRL_RESET;
			timeout_ff <= VS_TIMEOUT;
			ovf_ff     <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_ff  <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_ff  <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
			if (aw_ok_ff && w_ok_ff) begin
				aw_ok_ff  <= 1'b0;
				w_ok_ff   <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= `PVI_RESP_OKAY;
				case ({awaddr_ff[7:2], 2'b00})
					`PVI_ADDR_CTRL: begin
						if (wstrb_ff[0]) begin
							ctrl_ff <= wdata_ff[5:0];
						end
					end
					`PVI_ADDR_STATUS: begin
						if (wstrb_ff[0] && wdata_ff[`PVI_ST_OVERFLOW]) begin
							ovf_ff <= 1'b0;
						end
					end
					`PVI_ADDR_TIMEOUT: begin
						if (wstrb_ff[0]) timeout_ff[7:0]   <= wdata_ff[7:0];
						if (wstrb_ff[1]) timeout_ff[15:8]  <= wdata_ff[15:8];
						if (wstrb_ff[2]) timeout_ff[23:16] <= wdata_ff[23:16];
						if (wstrb_ff[3]) timeout_ff[31:24] <= wdata_ff[31:24];
					end
					`PVI_ADDR_FRM_IN, `PVI_ADDR_FRM_OUT, `PVI_ADDR_LINES: begin
						bresp_ff <= `PVI_RESP_OKAY;
					end
					default: bresp_ff <= `PVI_RESP_SLVERR;
				endcase
			end
			// Set wins over a clear in the same cycle
			if (ovf_set) begin
				ovf_ff <= 1'b1;
			end
		end
	end

	// AXI read: one access at a time, answered the cycle after the address
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= `PVI_RESP_OKAY;
		end else if (rvalid_ff) begin
			if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end else if (s_axi_arvalid) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= `PVI_RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				`PVI_ADDR_CTRL:    rdata_ff <= {26'h0, ctrl_ff};
				`PVI_ADDR_STATUS:  rdata_ff <= {26'h0, ~pix_out_valid, ovf_ff,
					masked_ff, glasses_ff, run_ff, run_ff};
				`PVI_ADDR_FRM_IN:  rdata_ff <= frm_in_ff;
				`PVI_ADDR_FRM_OUT: rdata_ff <= frm_out_ff;
				`PVI_ADDR_LINES:   rdata_ff <= lines_ff;
				`PVI_ADDR_TIMEOUT: rdata_ff <= timeout_ff;
				default: begin
					rdata_ff <= 32'h00000000;
					rresp_ff <= `PVI_RESP_SLVERR;
				end
			endcase
		end
	end
endmodule

/* verification/pvi_assertions.sv */
// Checker for the video input port's bus and stream behaviour
module pvi_assertions (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic        pix_out_valid,
	input logic        pix_out_ready,
	input logic [23:0] pix_out_data,
	input logic        pix_out_sof,
	input logic        pix_out_eye,
	input logic        glasses_sync,
	input logic        seq_run,
	input logic        illum_en
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Register bus: answer timing, refusal while busy, answers stand
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write response");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response moved");
	a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("late read data");
	a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
	// Stream side: a stalled word stays, no words without a running sequencer
	a_word_holds: assert property (pix_out_valid && !pix_out_ready |->
		##1 pix_out_valid && $stable(pix_out_data)) else $error("pixel word moved");
	a_idle_no_word: assert property (!seq_run && !pix_out_valid |=> !pix_out_valid)
		else $error("pixel word while halted");
	a_illum_follows: assert property (illum_en == seq_run)
		else $error("illumination differs from run");
	a_glasses_eye: assert property (pix_out_valid && pix_out_ready && pix_out_sof |->
		##1 glasses_sync == $past(pix_out_eye)) else $error("glasses sync wrong eye");
	c_frame_out: cover property (pix_out_valid && pix_out_ready && pix_out_sof);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	c_run_lost: cover property ($fell(seq_run));
endmodule

bind pvi_top pvi_assertions chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pix_out_valid, .pix_out_ready,
	.pix_out_data, .pix_out_sof, .pix_out_eye, .glasses_sync, .seq_run, .illum_en);

/* verification/pvi_src_model.sv */
// Pixel source model: syncs, gated pixel clock and pixel pins
module pvi_src_model (
	output logic        pixel_clk_in,
	output logic        frame_sync_in,
	output logic        line_sync_in,
	output logic        pixel_valid_in,
	output logic [23:0] pixel_bus_in,
	output logic        frame_update_mask,
	output logic        eye_select_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [23:0] px_q[$];

	// Idle pins; mask held low when unused
	initial begin
		pixel_clk_in = 1'b0;
		frame_sync_in = 1'b0;
		line_sync_in = 1'b0;
		pixel_valid_in = 1'b0;
		pixel_bus_in = 24'h0;
		frame_update_mask = 1'b0;
		eye_select_in = 1'b0;
	end

	// One eye frame; clock stands still outside lines, released pins show junk
	task automatic send_frame(input int nl, np, input logic vf, hf, mk, ey);
		frame_sync_in = vf;
		line_sync_in = hf;
		frame_update_mask = mk;
		eye_select_in = ey;
		#200 frame_sync_in = !vf;
		#200 frame_sync_in = vf;
		repeat (nl) begin
			#200 line_sync_in = !hf;
			#200 line_sync_in = hf;
			repeat (np) begin
				pixel_valid_in = 1'b1;
				pixel_bus_in = px_q.pop_front();
				#80 pixel_clk_in = 1'b1;
				#80 pixel_clk_in = 1'b0;
			end
			pixel_valid_in = 1'b0;
			pixel_bus_in = ~pixel_bus_in;
		end
		#400;
	endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench for the parallel video input port
`include "pvi_regs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] TMO = 32'h7D0;
	logic aclk = '0, aresetn = '0, stall = '0, fs, ls, eye_x;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, seed = 32'h4B2B, rs = 32'h4B2B, rv;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0, pix_out_ready = '0;
	logic [1:0] rsp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire pixel_clk_in, frame_sync_in, line_sync_in, pixel_valid_in, frame_update_mask;
	wire eye_select_in, pix_out_valid, pix_out_sof, pix_out_sol, pix_out_eye;
	wire glasses_sync, seq_run, illum_en;
	wire [23:0] pixel_bus_in, pix_out_data;
	logic [26:0] exp_q[$], got_q[$];
	int n_errors = 0, checks_done = 0, cap;

	always #10 aclk = ~aclk;
	pvi_top #(.VS_TIMEOUT(TMO)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pixel_clk_in, .frame_sync_in,
		.line_sync_in, .pixel_valid_in, .pixel_bus_in, .frame_update_mask, .eye_select_in,
		.pix_out_valid, .pix_out_ready, .pix_out_data, .pix_out_sof, .pix_out_sol, .pix_out_eye,
		.glasses_sync, .seq_run, .illum_en);
	pvi_src_model src_u (.pixel_clk_in, .frame_sync_in, .line_sync_in, .pixel_valid_in,
		.pixel_bus_in, .frame_update_mask, .eye_select_in);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] x6(input logic [5:0] v);
		return {v, v[5:4]};
	endfunction

	// Consumer stalls at random so the FIFO sees back-pressure
	always @(posedge aclk) begin
		rs <= lfsr(rs);
		pix_out_ready <= !stall && rs[0];
		if (pix_out_valid && pix_out_ready)
			got_q.push_back({pix_out_sof, pix_out_sol, pix_out_eye, pix_out_data});
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Bus master: offer both write halves, release each as taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Expected word with start-of-frame and start-of-line marks
	task automatic put(input logic [23:0] w);
		if (exp_q.size() < cap) exp_q.push_back({fs, ls, eye_x, w});
		fs = 1'b0;
		ls = 1'b0;
	endtask

	// Random frame through the source, then compare what comes out
	task automatic frame(input logic [1:0] fm, input int nl, np, input logic vf, hf, mk, ey,
		ok, st);
		logic [23:0] p;
		logic [7:0] y0, cb;
		fs = 1'b1;
		eye_x = ey;
		cap = st ? 16 : 1000;
		for (int l = 0; l < nl; l++) begin
			ls = 1'b1;
			for (int i = 0; i < np; i++) begin
				seed = lfsr(seed);
				p = seed[23:0];
				src_u.px_q.push_back(p);
				if (!ok) continue;
				if (fm == `PVI_FMT_24) put(p);
				else if (fm == `PVI_FMT_18) put({x6(p[17:12]), x6(p[11:6]), x6(p[5:0])});
				else if (!i[0]) {y0, cb} = p[15:0];
				else begin
					put({y0, cb, p[7:0]});
					put({p[15:8], cb, p[7:0]});
				end
			end
		end
		#5 stall = st;
		src_u.send_frame(nl, np, vf, hf, mk, ey);
		stall = 1'b0;
		for (int t = 0; t < 400 && got_q.size() < exp_q.size(); t++) @(posedge aclk);
		repeat (20) @(posedge aclk);
		chk("word count", exp_q.size(), got_q.size());
		while (exp_q.size() && got_q.size())
			chk("pixel word", exp_q.pop_front(), got_q.pop_front());
		$display("test frame fmt %0d mask %0d done", fm, mk);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Hang guard well past the expected run length
	initial begin
		repeat (40000) @(posedge aclk);
		n_errors++;
		finish_test;
	end

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axr(`PVI_ADDR_CTRL);
		chk("ctrl reset", `PVI_CTRL_RESET, rv);
		axr(`PVI_ADDR_TIMEOUT);
		chk("timeout reset", TMO, rv);
		axr(8'h20);
		chk("unmapped read", `PVI_RESP_SLVERR, rsp);
		axw(8'h20, 32'hFFFFFFFF);
		chk("unmapped write", `PVI_RESP_SLVERR, rsp);
		$display("test registers done");
		// Every format and every sync edge choice, eyes alternating
		for (int k = 0; k < 4; k++) begin
			axw(`PVI_ADDR_CTRL, {26'h0, 2'(k % 3), 1'b0, k[1], k[0], 1'b1});
			frame(2'(k % 3), 3, 6, k[0], k[1], 1'b0, k[0], 1'b1, 1'b0);
			chk("glasses sync", k[0], glasses_sync);
		end
		axr(`PVI_ADDR_FRM_OUT);
		chk("frames out", 32'h4, rv);
		axr(`PVI_ADDR_LINES);
		chk("lines per frame", 32'h3, rv);
		// Mask with both polarities
		axw(`PVI_ADDR_CTRL, 32'h1);
		frame(`PVI_FMT_24, 2, 4, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		axw(`PVI_ADDR_CTRL, 32'h9);
		frame(`PVI_FMT_24, 2, 4, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		frame(`PVI_FMT_24, 2, 4, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
		axr(`PVI_ADDR_FRM_OUT);
		chk("frames out after mask", 32'h5, rv);
		axr(`PVI_ADDR_FRM_IN);
		chk("frames in", 32'h7, rv);
		// Fill the FIFO past full while stalled, then drain
		frame(`PVI_FMT_24, 1, 20, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
		axr(`PVI_ADDR_STATUS);
		chk("overflow flag", 1'b1, rv[`PVI_ST_OVERFLOW]);
		axw(`PVI_ADDR_STATUS, 32'h10);
		axr(`PVI_ADDR_STATUS);
		chk("overflow cleared", 1'b0, rv[`PVI_ST_OVERFLOW]);
		chk("fifo empty", 1'b1, rv[`PVI_ST_EMPTY]);
		$display("test overflow done");
		// Frame sync lost: sequencer and illumination drop
		chk("sequencer running", 32'h1, seq_run);
		repeat (TMO + 100) @(posedge aclk);
		chk("sequencer run", 1'b0, seq_run);
		chk("illumination", 1'b0, illum_en);
		$display("test frame sync loss done");
		finish_test;
	end
endmodule
